// ### bench/tcmp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// host controller: sends messages, takes responses
// ------------------------------------------------------------
module tcmp_host_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txEnd,
  output logic rxValid = 1'b0,
  output logic [7:0] rxData = 8'h00,
  output logic rxEnd = 1'b0,
  output logic txReady = 1'b1,
  output logic [7:0] lastChar = 8'h00,
  output int nResp = 0
);
  // a slow host stalls every other cycle to stretch the handshake
  always @(negedge clk) txReady <= slow ? ~txReady : 1'b1;
  // count whole responses, keep the data character
  always @(posedge clk) begin
    if (txValid && txReady) begin
      if (txEnd) nResp <= nResp + 1;
      else lastChar <= txData;
    end
  end
  // bytes back to back, new line with end marker closes the message
  task automatic sendMsg(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk);
      rxValid <= 1'b1;
      rxData <= s[i];
    end
    @(negedge clk);
    rxData <= 8'h0A;
    rxEnd <= 1'b1;
    @(negedge clk);
    rxValid <= 1'b0;
    rxEnd <= 1'b0;
    rxData <= 8'hF5; // released line shows junk, not the last byte
  endtask
endmodule
`default_nettype wire

// ### bench/tcmp_parser_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// port protocol checks for the parser
// ------------------------------------------------------------
module tcmp_parser_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxEnd,
  input wire logic txReady,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txEnd,
  input wire logic levelLoopControl,
  input wire logic syntaxError,
  input wire logic commonCmd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // a separator byte is where commands execute
  wire logic sep = rxValid && clkEn && (rxEnd || rxData == 8'h0A ||
    rxData == 8'h3B);
  sequence sAccept;
    txValid && txReady && clkEn && !txEnd;
  endsequence
  sequence sTail;
    !txValid ##1 (txValid && txEnd && txData == 8'h0A);
  endsequence
  chk_rx_always: assert property (rxReady)
    else $error("input stalled");
  chk_end_byte: assert property (txEnd |-> txValid && txData == 8'h0A)
    else $error("end marker off new line");
  chk_resp_pair: assert property (sAccept |=> sTail)
    else $error("response not closed by new line");
  // the data byte appears two edges after the query's separator, or
  // right after an earlier response byte has been taken
  chk_resp_cause: assert property ($rose(txValid) && txData != 8'h0A
    |-> $past(sep, 2) || $past(txValid, 2))
    else $error("unsolicited response");
  chk_resp_char: assert property (txValid && !txEnd |->
    txData inside {8'h30, 8'h31, 8'h49}) else $error("bad response char");
  chk_resp_hold: assert property (txValid && !(txReady && clkEn) |=>
    txValid && $stable(txData)) else $error("response dropped");
  chk_err_sticky: assert property (syntaxError |=> syntaxError)
    else $error("error flag lost");
  chk_common_one: assert property (commonCmd |=> !commonCmd)
    else $error("common pulse too long");
  chk_common_sep: assert property ($rose(commonCmd) |-> $past(sep))
    else $error("common pulse without separator");
  chk_loop_sep: assert property ($changed(levelLoopControl) |->
    $past(sep)) else $error("loop control moved off separator");
endmodule
bind tcmp_parser tcmp_parser_sva u_sva (.clk(clk), .sys_rst(sys_rst),
  .clkEn(clkEn), .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
  .txReady(txReady), .rxReady(rxReady), .txValid(txValid),
  .txData(txData), .txEnd(txEnd), .levelLoopControl(levelLoopControl),
  .syntaxError(syntaxError), .commonCmd(commonCmd));
`default_nettype wire

// ### bench/tcmp_parser_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tcmp_parser_tb;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic slow = 1'b0;
  logic clkEn = 1'b1;
  int nCommon = 0;
  int n_fail = 0;
  int samples_checked = 0;
  wire logic rxValid, rxEnd, txReady, rxReady, txValid, txEnd;
  wire logic levelLoopControl, syntaxError, commonCmd;
  wire logic [7:0] rxData, txData, lastChar;
  int nResp;
  // clock enable is dropped in one scenario to check the freeze
  tcmp_parser dut (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn),
    .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd), .txReady(txReady),
    .rxReady(rxReady), .txValid(txValid), .txData(txData), .txEnd(txEnd),
    .levelLoopControl(levelLoopControl), .syntaxError(syntaxError),
    .commonCmd(commonCmd));
  tcmp_host_model host (.clk(clk), .slow(slow), .txValid(txValid),
    .txData(txData), .txEnd(txEnd), .rxValid(rxValid), .rxData(rxData),
    .rxEnd(rxEnd), .txReady(txReady), .lastChar(lastChar), .nResp(nResp));
  // ------------------------------------------------------------
  // clock, pulse capture and helpers
  // ------------------------------------------------------------
  always #25 clk = ~clk;
  // one-cycle pulse is easy to miss, so count it
  always @(posedge clk) if (commonCmd === 1'b1) nCommon <= nCommon + 1;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // send and wait a bounded time for replies; returns how many came
  task automatic talk(input string s, output logic [7:0] cnt);
    int n0;
    n0 = nResp;
    host.sendMsg(s);
    for (int i = 0; i < 60; i++) @(negedge clk);
    cnt = 8'(nResp - n0);
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic tWalk;
    logic [7:0] c;
    talk("POW:LOOP:STAT?", c);
    chk(c, 8'h01);
    chk(lastChar, 8'h30);
    $display("walk done");
  endtask
  task automatic tOnWord;
    logic [7:0] c;
    talk(":POWER:loopctl:state ON", c);
    chk(c, 8'h00);
    chk({7'h00, levelLoopControl}, 8'h01);
    talk("pOw:LoOp:StAt?", c);
    chk(c, 8'h01);
    chk(lastChar, 8'h31);
    $display("on word done");
  endtask
  task automatic tSemi;
    logic [7:0] c;
    slow = 1'b1;
    talk("POW:LOOP:STAT 0;STAT?", c);
    chk(lastChar, 8'h30);
    talk("POW:LOOP:STAT 1;STAT?", c);
    chk(lastChar, 8'h31);
    slow = 1'b0;
    $display("semicolon done");
  endtask
  task automatic tCommon;
    logic [7:0] c;
    int n0;
    n0 = nCommon;
    talk("POW:LOOP:STAT 1;*RST", c);
    chk(8'(nCommon - n0), 8'h01);
    chk({7'h00, levelLoopControl}, 8'h00);
    talk("*IDN?", c);
    chk(c, 8'h01);
    chk(lastChar, 8'h49);
    $display("common done");
  endtask
  task automatic tReject;
    logic [7:0] c;
    talk("POWE:LOOP:STAT?", c);
    chk(c, 8'h00);
    chk({7'h00, syntaxError}, 8'h01);
    talk("POW:LOOP:STAT 0", c);
    chk(c, 8'h00);
    talk("STAT?", c);
    chk(c, 8'h00);
    $display("reject done");
  endtask
  task automatic tFreeze;
    logic [7:0] c;
    clkEn = 1'b0;
    talk("POW:LOOP:STAT 1;STAT?", c);
    clkEn = 1'b1;
    chk(c, 8'h00);
    chk({7'h00, levelLoopControl}, 8'h00);
    $display("freeze done");
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    sysRst = 1'b0;
    tWalk();
    tOnWord();
    tSemi();
    tCommon();
    tReject();
    tFreeze();
    close_out();
  end
  // about 900 cycles expected; allow about nine times that
  initial begin
    #400000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire

// ### core/tcmp_defines.vh
`ifndef TCMP_DEFINES_VH
`define TCMP_DEFINES_VH
// ------------------------------------------------------------
// character codes
// ------------------------------------------------------------
`define TCMP_CH_NL 8'h0A
`define TCMP_CH_SEMI 8'h3B
`define TCMP_CH_COLON 8'h3A
`define TCMP_CH_STAR 8'h2A
`define TCMP_CH_QUERY 8'h3F
`define TCMP_CH_SPACE 8'h20
`define TCMP_CH_TAB 8'h09
`define TCMP_CH_ZERO 8'h30
`define TCMP_CH_ONE 8'h31
// ------------------------------------------------------------
// keyword codes from the matcher
// ------------------------------------------------------------
`define TCMP_KW_NONE 3'h0
`define TCMP_KW_POWER 3'h1
`define TCMP_KW_LOOP 3'h2
`define TCMP_KW_STATE 3'h3
`define TCMP_KW_RST 3'h4
`define TCMP_KW_IDN 3'h5
`define TCMP_KW_OFF 3'h6
`define TCMP_KW_ON 3'h7
// ------------------------------------------------------------
// sizes and reset values
// ------------------------------------------------------------
`define TCMP_KW_MAXLEN 4'h8
`define TCMP_LOOP_RST 1'b0
`define TCMP_IDN_CHAR 8'h49
`endif

// ### core/tcmp_keyword_match.v
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// keyword table lookup: short or long form, case folded
// ------------------------------------------------------------
`include "tcmp_defines.vh"
module tcmp_keyword_match (
  input wire [63:0] word,
  input wire [3:0] len,
  output reg [2:0] code
);
  // keeps the low n bytes of a table string; the parser shifts
  // letters in at the bottom, so both sides are right-justified
  function [63:0] pack;
    input [63:0] s;
    input [3:0] n;
    begin
      pack = s & ~({64{1'b1}} << {n, 3'h0});
    end
  endfunction

  // only exact short or exact long forms hit; any in-between
  // length misses, so mixed spellings are rejected
  always @* begin
    code = `TCMP_KW_NONE;
    if ((len == 4'h3 && word == pack("POW", 4'h3)) ||
        (len == 4'h5 && word == pack("POWER", 4'h5)))
      code = `TCMP_KW_POWER;
    else if ((len == 4'h4 && word == pack("LOOP", 4'h4)) ||
        (len == 4'h7 && word == pack("LOOPCTL", 4'h7)))
      code = `TCMP_KW_LOOP;
    else if ((len == 4'h4 && word == pack("STAT", 4'h4)) ||
        (len == 4'h5 && word == pack("STATE", 4'h5)))
      code = `TCMP_KW_STATE;
    else if (len == 4'h4 && word == pack("*RST", 4'h4))
      code = `TCMP_KW_RST;
    else if (len == 4'h4 && word == pack("*IDN", 4'h4))
      code = `TCMP_KW_IDN;
    else if (len == 4'h3 && word == pack("OFF", 4'h3))
      code = `TCMP_KW_OFF;
    else if (len == 4'h2 && word == pack("ON", 4'h2))
      code = `TCMP_KW_ON;
  end
endmodule
`default_nettype wire

// ### core/tcmp_parser.v
// How it works
// (R01) accept only exact short or long keywords
// (R02) keyword matching ignores letter case
// (R03) new line terminator is code 10
// (R04) end marker rides with the last byte
// (R05) responses end in new line with end
// (R06) input byte always accepted, never stalled
// (R07) responses sent only after a query
// (R08) trailing question mark marks a query
// (R09) every setting has a matching query
// (R10) ON and 1 both switch function on
// (R11) on state always answers numeral 1
// (R12) asterisk prefix marks a common command
// (R13) colons split keywords into hierarchy levels
// (R14) several commands per message are handled
// (R15) terminator returns hierarchy to root
// (R16) colon descends; leading colon selects root
// (R17) semicolon keeps the hierarchy position
// (R18) reset and reset command select root
// (R19) unknown keyword discards command, flags error
// (R20) letters folded to upper case before matching
`timescale 1ns/100ps
`default_nettype none
`include "tcmp_defines.vh"
module tcmp_parser (
  input wire clk,
  input wire sys_rst,
  input wire clkEn,
  input wire rxValid,
  input wire [7:0] rxData,
  input wire rxEnd,
  input wire txReady,
  output wire rxReady,
  output reg txValid,
  output reg [7:0] txData,
  output reg txEnd,
  output reg levelLoopControl,
  output reg syntaxError,
  output reg commonCmd
);
  // ------------------------------------------------------------
  // parser states
  // ------------------------------------------------------------
  localparam [2:0] ST_KEY = 3'b001;
  localparam [2:0] ST_PARAM = 3'b010;
  localparam [2:0] ST_SKIP = 3'b100;

  reg [2:0] state;
  reg [63:0] word;
  reg [3:0] len;
  reg [1:0] level;
  reg pathPower;
  reg pathLoop;
  reg isQuery;
  reg isCommon;
  reg badWord;
  reg [7:0] paramChar;
  reg [1:0] pendResp;
  reg [7:0] respChar;
  wire [2:0] code;

  // fold lower case letters to upper case
  function [7:0] upcase;
    input [7:0] c;
    begin
      if (c >= 8'h61 && c <= 8'h7A)
        upcase = c - 8'h20;
      else
        upcase = c;
    end
  endfunction

  // true for any byte that ends a command
  function isSep;
    input [7:0] c;
    input e;
    begin
      isSep = e || c == `TCMP_CH_NL || c == `TCMP_CH_SEMI;
    end
  endfunction

  tcmp_keyword_match u_match (
    .word(word),
    .len(len),
    .code(code)
  );

  // never back-pressures the controller
  assign rxReady = 1'b1; // [R06]

  wire take = clkEn && rxValid;
  wire [7:0] ch = upcase(rxData); // [R02] [R20]
  wire endMsg = rxEnd || rxData == `TCMP_CH_NL; // [R03] [R04]
  wire isWs = rxData == `TCMP_CH_SPACE || rxData == `TCMP_CH_TAB;

  // ------------------------------------------------------------
  // command execution at a separator
  // ------------------------------------------------------------
  // keyword at current level: two levels deep under POWER
  wire leafOk = (level == 2'h0 && code == `TCMP_KW_POWER) ||
    (level == 2'h1 && pathPower && code == `TCMP_KW_LOOP) ||
    (level == 2'h2 && pathLoop && code == `TCMP_KW_STATE);
  wire commonOk = code == `TCMP_KW_RST || code == `TCMP_KW_IDN;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_KEY;
      word <= 64'h0;
      len <= 4'h0;
      level <= 2'h0;
      pathPower <= 1'b0;
      pathLoop <= 1'b0;
      isQuery <= 1'b0;
      isCommon <= 1'b0;
      badWord <= 1'b0;
      paramChar <= 8'h00;
      pendResp <= 2'h0;
      respChar <= 8'h00;
      levelLoopControl <= `TCMP_LOOP_RST;
      syntaxError <= 1'b0;
      commonCmd <= 1'b0;
      txValid <= 1'b0;
      txData <= 8'h00;
      txEnd <= 1'b0;
    end else if (clkEn) begin
      commonCmd <= 1'b0;
      // response output: byte then new line with end marker
      if (txValid && txReady) begin
        txValid <= 1'b0;
        txEnd <= 1'b0;
      end else if (!txValid && pendResp == 2'h2) begin
        txValid <= 1'b1;
        txData <= respChar;
        pendResp <= 2'h1;
      end else if (!txValid && pendResp == 2'h1) begin
        txValid <= 1'b1;
        txData <= `TCMP_CH_NL; // [R05]
        txEnd <= 1'b1; // [R05]
        pendResp <= 2'h0;
      end
      if (take) begin
        if (isSep(rxData, rxEnd)) begin
          // evaluate the command just collected [R14]
          if (state != ST_SKIP && len != 4'h0) begin
            if (isCommon) begin // [R12]
              if (badWord || !commonOk) begin
                syntaxError <= 1'b1; // [R19]
              end else begin
                commonCmd <= 1'b1;
                if (code == `TCMP_KW_RST) begin
                  levelLoopControl <= `TCMP_LOOP_RST;
                  level <= 2'h0; // [R18]
                  pathPower <= 1'b0;
                  pathLoop <= 1'b0;
                end else if (isQuery && pendResp == 2'h0) begin
                  respChar <= `TCMP_IDN_CHAR;
                  pendResp <= 2'h2; // [R07]
                end
              end
            end else if (badWord || !leafOk) begin
              syntaxError <= 1'b1; // [R19] [R01]
            end else if (code == `TCMP_KW_STATE && isQuery) begin
              // the readback always uses the numeral [R09] [R11]
              if (pendResp == 2'h0) begin
                respChar <= levelLoopControl ? `TCMP_CH_ONE :
                  `TCMP_CH_ZERO;
                pendResp <= 2'h2; // [R07] [R08]
              end
            end else if (code == `TCMP_KW_STATE) begin
              // ON and 1 are equivalent [R10]
              if (paramChar == `TCMP_CH_ONE ||
                  paramChar == `TCMP_KW_ON)
                levelLoopControl <= 1'b1;
              else if (paramChar == `TCMP_CH_ZERO ||
                  paramChar == `TCMP_KW_OFF)
                levelLoopControl <= 1'b0;
              else
                syntaxError <= 1'b1; // [R19]
            end
          end
          // semicolon keeps the path; terminator returns to root
          if (endMsg) begin
            level <= 2'h0; // [R15]
            pathPower <= 1'b0;
            pathLoop <= 1'b0;
          end // [R17]
          state <= ST_KEY;
          word <= 64'h0;
          len <= 4'h0;
          isQuery <= 1'b0;
          isCommon <= 1'b0;
          badWord <= 1'b0;
          paramChar <= 8'h00;
        end else begin
          case (state)
            ST_KEY: begin
              if (rxData == `TCMP_CH_COLON) begin
                if (len == 4'h0) begin
                  level <= 2'h0; // [R16]
                  pathPower <= 1'b0;
                  pathLoop <= 1'b0;
                end else if (code == `TCMP_KW_POWER &&
                    level == 2'h0 && !badWord) begin
                  level <= 2'h1; // [R13] [R16]
                  pathPower <= 1'b1;
                end else if (code == `TCMP_KW_LOOP &&
                    level == 2'h1 && pathPower && !badWord) begin
                  level <= 2'h2; // [R13] [R16]
                  pathLoop <= 1'b1;
                end else begin
                  // discard the rest of this command
                  syntaxError <= 1'b1; // [R19]
                  state <= ST_SKIP;
                end
                word <= 64'h0;
                len <= 4'h0;
              end else if (rxData == `TCMP_CH_STAR && len == 4'h0) begin
                // common commands work whatever the current path is
                isCommon <= 1'b1; // [R12]
                word <= {56'h0, ch};
                len <= 4'h1;
              end else if (rxData == `TCMP_CH_QUERY) begin
                isQuery <= 1'b1; // [R08]
              end else if (isWs) begin
                if (len != 4'h0)
                  state <= ST_PARAM;
              end else if (isQuery ||
                  len == `TCMP_KW_MAXLEN) begin
                badWord <= 1'b1;
              end else begin
                word <= {word[55:0], ch}; // [R20]
                len <= len + 4'h1;
              end
            end
            ST_PARAM: begin
              // second word is matched via first letters only
              if (!isWs && paramChar == 8'h00) begin
                if (ch == `TCMP_CH_ONE || ch == `TCMP_CH_ZERO)
                  paramChar <= ch;
                else if (ch == 8'h4F)
                  paramChar <= {5'h0, `TCMP_KW_OFF};
              end else if (paramChar == {5'h0, `TCMP_KW_OFF} &&
                  ch == 8'h4E) begin
                paramChar <= {5'h0, `TCMP_KW_ON}; // [R10]
              end
            end
            ST_SKIP: begin
            end
            default: state <= ST_KEY;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire
